// ===== hw/pspc_core.sv
// Processing state and privilege control for a 32-bit processor.
// Assumes decoded instruction strobes from the integer_unit, one cycle each.
//
// Behaviour
// - Always in exactly one of normal, exception or halted state.
// - Trace, trap or specific instructions start exception processing.
// - Exception runs stacking, vector fetch, refill; ends at first handler op.
// - Access or address error during exception processing halts.
// - Halted stays halted until external reset.
// - Stop gives a bus-idle normal substate, distinct from halt.
// - Supervisor flag set means supervisor mode, clear means user.
// - Exception bus cycles are supervisor, stacking uses supervisor stack.
// - Transfer modifier shows supervisor or user for each bus cycle.
// - Exception entry pushes status word, then sets supervisor flag.
// - Privileged instructions run only in supervisor mode.
// - Traps, trace and refused instructions are the only user paths into supervisor mode.
// - Status word writes and return from exception flush the pipeline.
// - User mode reaches only user registers; supervisor reaches all.
// - User set: sixteen 32-bit general registers plus two control.
// - Translation registers are reached only from supervisor mode.
// - User mode writes only the condition flag byte of the status word.
`timescale 1ns/1ns
`default_nettype none

module pspc_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Instruction events
    input wire logic instr_valid,
    input wire logic instr_privileged,
    input wire logic instr_stop,
    input wire logic instr_trap,
    input wire logic [3:0] trap_num,
    input wire logic trace_pending,
    input wire logic instr_sw_write,
    input wire logic instr_rfe,
    input wire logic [15:0] sw_wdata,
    input wire logic [15:0] rfe_sw,
    input wire logic handler_first,
    input wire logic wake_event,
    // Register access check
    input wire logic reg_acc_valid,
    input wire logic [5:0] reg_acc_idx,
    // General register file port
    input wire logic gpr_we,
    input wire logic [3:0] gpr_waddr,
    input wire logic [31:0] gpr_wdata,
    input wire logic [3:0] gpr_raddr,
    output logic [31:0] gpr_rdata,
    // Bus cycle qualifiers
    input wire logic bus_req,
    input wire logic bus_prog,
    input wire logic bus_done,
    input wire logic access_error,
    input wire logic address_error,
    output logic [2:0] tm_out,
    output logic bus_allowed,
    output logic stack_super,
    // Status and control
    output logic [15:0] status_word,
    output logic [7:0] condition_flag_byte,
    output logic super_mode,
    output logic [1:0] proc_state,
    output logic stopped,
    output logic halted,
    output logic pipe_flush,
    output logic sw_push,
    output logic [15:0] sw_push_data,
    output logic vector_fetch,
    output logic [7:0] vector_num,
    output logic instr_refused,
    output logic reg_acc_refused
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pspc_pkg::pspc_state_t state_q;
    pspc_pkg::pspc_step_t step_q;
    logic [15:0] sw_q;
    logic [15:0] saved_sw_q;
    logic [7:0] vec_q;
    logic [1:0] fill_q;
    logic stopped_q;
    logic flush_q;
    logic [31:0] gpr_q [pspc_pkg::GPR_COUNT];
    logic [31:0] rdata_q;
    logic ex_cause;
    logic priv_fault;
    logic fault_any;

    // ------------------------------------------------------------------
    // Privilege checks
    // ------------------------------------------------------------------
    pspc_priv_check u_check (
        .super_mode(super_mode),
        .instr_valid(instr_valid),
        .instr_privileged(instr_privileged),
        .reg_acc_valid(reg_acc_valid),
        .reg_acc_idx(reg_acc_idx),
        .instr_refused(instr_refused),
        .reg_acc_refused(reg_acc_refused)
    );

    assign super_mode = sw_q[pspc_pkg::SW_SUPER_BIT];
    assign priv_fault = instr_refused;
    assign fault_any = access_error || address_error;

    // Only traps, trace and refused instructions enter the supervisor.
    assign ex_cause = (state_q == pspc_pkg::PSPC_NORMAL) &&
                      ((instr_valid && instr_trap) || trace_pending ||
                       priv_fault);

    // ------------------------------------------------------------------
    // Processing state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= pspc_pkg::PSPC_NORMAL;
        end else begin
            unique case (state_q)
                pspc_pkg::PSPC_NORMAL: begin
                    if (ex_cause) begin
                        state_q <= pspc_pkg::PSPC_EXCEPTION;
                    end
                end
                pspc_pkg::PSPC_EXCEPTION: begin
                    if (fault_any) begin
                        state_q <= pspc_pkg::PSPC_HALTED;
                    end else if (step_q == pspc_pkg::PSPC_EX_WAIT_FIRST &&
                                 handler_first) begin
                        state_q <= pspc_pkg::PSPC_NORMAL;
                    end
                end
                pspc_pkg::PSPC_HALTED: begin
                    state_q <= pspc_pkg::PSPC_HALTED;
                end
                default: begin
                    state_q <= pspc_pkg::PSPC_HALTED;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Exception sequence
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            step_q <= pspc_pkg::PSPC_EX_IDLE;
            fill_q <= 2'h0;
        end else if ((fault_any && state_q == pspc_pkg::PSPC_EXCEPTION) ||
                     state_q == pspc_pkg::PSPC_HALTED) begin
            // An error outside exception processing must not cancel an entry.
            step_q <= pspc_pkg::PSPC_EX_IDLE;
        end else begin
            unique case (step_q)
                pspc_pkg::PSPC_EX_IDLE: begin
                    if (ex_cause) begin
                        step_q <= pspc_pkg::PSPC_EX_PUSH;
                    end
                end
                pspc_pkg::PSPC_EX_PUSH: begin
                    if (bus_done) begin
                        step_q <= pspc_pkg::PSPC_EX_SETS;
                    end
                end
                pspc_pkg::PSPC_EX_SETS: begin
                    step_q <= pspc_pkg::PSPC_EX_VECTOR;
                end
                pspc_pkg::PSPC_EX_VECTOR: begin
                    if (bus_done) begin
                        step_q <= pspc_pkg::PSPC_EX_FILL;
                        fill_q <= 2'h0;
                    end
                end
                pspc_pkg::PSPC_EX_FILL: begin
                    if (bus_done) begin
                        if (fill_q == pspc_pkg::FILL_WORDS) begin
                            step_q <= pspc_pkg::PSPC_EX_WAIT_FIRST;
                        end
                        fill_q <= fill_q + 2'h1;
                    end
                end
                pspc_pkg::PSPC_EX_WAIT_FIRST: begin
                    if (handler_first) begin
                        step_q <= pspc_pkg::PSPC_EX_IDLE;
                    end
                end
                default: begin
                    step_q <= pspc_pkg::PSPC_EX_IDLE;
                end
            endcase
        end
    end

    // Vector number and status word snapshot at exception entry.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vec_q <= 8'h00;
            saved_sw_q <= 16'h0000;
        end else if (ex_cause) begin
            saved_sw_q <= sw_q;
            if (priv_fault) begin
                vec_q <= pspc_pkg::VEC_PRIV_VIOLATION;
            end else if (instr_valid && instr_trap) begin
                vec_q <= pspc_pkg::VEC_TRAP_BASE + {4'h0, trap_num};
            end else begin
                vec_q <= pspc_pkg::VEC_TRACE;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sw_q <= pspc_pkg::SW_RESET;
        end else if (step_q == pspc_pkg::PSPC_EX_SETS) begin
            sw_q[pspc_pkg::SW_SUPER_BIT] <= 1'b1;
        end else if (state_q == pspc_pkg::PSPC_NORMAL && instr_valid &&
                     !instr_refused) begin
            if (instr_rfe && super_mode) begin
                sw_q <= rfe_sw;
            end else if (instr_sw_write && super_mode) begin
                sw_q <= sw_wdata;
            end else if (instr_sw_write) begin
                // User code may only change the condition flag byte.
                sw_q <= (sw_q & ~pspc_pkg::SW_FLAG_BYTE_MASK) |
                        (sw_wdata & pspc_pkg::SW_FLAG_BYTE_MASK);
            end
        end
    end

    // Pipeline flush after any status word write or return.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flush_q <= 1'b0;
        end else begin
            flush_q <= state_q == pspc_pkg::PSPC_NORMAL && instr_valid &&
                       !instr_refused && (instr_sw_write ||
                       instr_rfe);
        end
    end

    // ------------------------------------------------------------------
    // Stopped substate
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stopped_q <= 1'b0;
        end else if (state_q != pspc_pkg::PSPC_NORMAL || trace_pending) begin
            stopped_q <= 1'b0;
        end else if (instr_valid && instr_stop && !instr_refused) begin
            // A stop in the same cycle as a wake event still stops.
            stopped_q <= 1'b1;
        end else if (wake_event) begin
            stopped_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // General register file
    // ------------------------------------------------------------------
    // Sixteen 32-bit general registers; no reset so they map to storage.
    always_ff @(posedge clk_sys) begin
        if (gpr_we) begin
            gpr_q[gpr_waddr] <= gpr_wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= gpr_q[gpr_raddr];
        end
    end

    // ------------------------------------------------------------------
    // Bus qualifiers and outputs
    // ------------------------------------------------------------------
    always_comb begin
        if (state_q == pspc_pkg::PSPC_EXCEPTION || super_mode) begin
            tm_out = bus_prog ? pspc_pkg::TM_SUPER_PROG :
                     pspc_pkg::TM_SUPER_DATA;
        end else begin
            tm_out = bus_prog ? pspc_pkg::TM_USER_PROG :
                     pspc_pkg::TM_USER_DATA;
        end
    end

    assign bus_allowed = bus_req && !stopped_q &&
                         state_q != pspc_pkg::PSPC_HALTED;
    assign stack_super = state_q == pspc_pkg::PSPC_EXCEPTION;
    assign status_word = sw_q;
    assign condition_flag_byte = sw_q[7:0];
    assign proc_state = state_q;
    assign stopped = stopped_q;
    assign halted = state_q == pspc_pkg::PSPC_HALTED;
    assign pipe_flush = flush_q;
    assign sw_push = step_q == pspc_pkg::PSPC_EX_PUSH;
    assign sw_push_data = saved_sw_q;
    assign vector_fetch = step_q == pspc_pkg::PSPC_EX_VECTOR;
    assign vector_num = vec_q;
    assign gpr_rdata = rdata_q;

endmodule : pspc_core

`default_nettype wire

// ===== hw/pspc_pkg.sv
// Package for the processor state and privilege control block.
// Assumes a single clock domain and no software-visible registers.
package pspc_pkg;

    // ------------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------------
    localparam int SW_WIDTH = 16;
    localparam int SW_SUPER_BIT = 13;
    localparam int SW_FLAG_BYTE_W = 8;
    localparam logic [15:0] SW_RESET = 16'h2700;
    localparam logic [15:0] SW_FLAG_BYTE_MASK = 16'h00ff;

    // ------------------------------------------------------------------
    // Register file layout
    // ------------------------------------------------------------------
    localparam int GPR_COUNT = 16;
    localparam int GPR_WIDTH = 32;
    localparam int REG_IDX_W = 6;
    localparam int USER_CTRL_COUNT = 2;
    localparam logic [5:0] REG_IDX_PC = 6'h10;
    localparam logic [5:0] REG_IDX_FLAGS = 6'h11;
    localparam logic [5:0] REG_IDX_FIRST_SUPER = 6'h12;
    localparam logic [5:0] REG_IDX_XLATE_FIRST = 6'h18;
    localparam logic [5:0] REG_IDX_XLATE_LAST = 6'h1b;

    // ------------------------------------------------------------------
    // Transfer modifier encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] TM_USER_DATA = 3'h1;
    localparam logic [2:0] TM_USER_PROG = 3'h2;
    localparam logic [2:0] TM_SUPER_DATA = 3'h5;
    localparam logic [2:0] TM_SUPER_PROG = 3'h6;

    // ------------------------------------------------------------------
    // Exception vector numbers and refill count
    // ------------------------------------------------------------------
    localparam logic [7:0] VEC_PRIV_VIOLATION = 8'h08;
    localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
    localparam logic [7:0] VEC_TRACE = 8'h09;
    localparam int FILL_WIDTH = 2;
    localparam logic [1:0] FILL_WORDS = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PSPC_NORMAL,
        PSPC_EXCEPTION,
        PSPC_HALTED
    } pspc_state_t;

    typedef enum logic [2:0] {
        PSPC_EX_IDLE,
        PSPC_EX_PUSH,
        PSPC_EX_SETS,
        PSPC_EX_VECTOR,
        PSPC_EX_FILL,
        PSPC_EX_WAIT_FIRST
    } pspc_step_t;

endpackage : pspc_pkg

// ===== hw/pspc_priv_check.sv
// Privilege checker for instruction and register accesses.
// Assumes decoded instruction class flags from the integer_unit decoder.
`timescale 1ns/1ns
`default_nettype none

module pspc_priv_check (
    // Mode
    input wire logic super_mode,
    // Instruction class
    input wire logic instr_valid,
    input wire logic instr_privileged,
    // Register access
    input wire logic reg_acc_valid,
    input wire logic [5:0] reg_acc_idx,
    // Results
    output logic instr_refused,
    output logic reg_acc_refused
);

    logic user_reg;
    logic xlate_reg;

    // User code sees only the general registers and two control registers.
    assign user_reg = reg_acc_idx < pspc_pkg::REG_IDX_FIRST_SUPER;
    assign xlate_reg = (reg_acc_idx >= pspc_pkg::REG_IDX_XLATE_FIRST) &&
                       (reg_acc_idx <= pspc_pkg::REG_IDX_XLATE_LAST);

    assign instr_refused = instr_valid && instr_privileged &&
                           !super_mode;
    assign reg_acc_refused = reg_acc_valid && !super_mode &&
                             (!user_reg || xlate_reg);

endmodule : pspc_priv_check

`default_nettype wire

// ===== verification/pspc_core_monitor.sv
// Checker for the processor state and privilege control block.
// Assumes it is bound to pspc_core and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none

module pspc_core_monitor (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Instruction and bus inputs
    input wire logic instr_valid,
    input wire logic instr_privileged,
    input wire logic instr_trap,
    input wire logic instr_sw_write,
    input wire logic instr_rfe,
    input wire logic bus_req,
    input wire logic bus_prog,
    input wire logic access_error,
    input wire logic address_error,
    // Outputs under watch
    input wire logic [2:0] tm_out,
    input wire logic bus_allowed,
    input wire logic stack_super,
    input wire logic [15:0] status_word,
    input wire logic [7:0] condition_flag_byte,
    input wire logic super_mode,
    input wire logic [1:0] proc_state,
    input wire logic stopped,
    input wire logic halted,
    input wire logic pipe_flush,
    input wire logic sw_push,
    input wire logic [15:0] sw_push_data,
    input wire logic vector_fetch,
    input wire logic instr_refused
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_state_legal;
        proc_state != 2'h3 && halted == (proc_state == 2'h2);
    endproperty
    a_state_legal: assert property (p_state_legal)
        else $error("illegal processing state");
    property p_halt_hold;
        halted |=> halted && !bus_allowed;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("left halted state without reset");
    property p_double_fault;
        proc_state == 2'h1 && (access_error || address_error) |=> halted;
    endproperty
    a_double_fault: assert property (p_double_fault)
        else $error("error during exception did not halt");
    property p_tm;
        bus_req |-> tm_out ==
            {super_mode || proc_state == 2'h1, bus_prog, !bus_prog};
    endproperty
    a_tm: assert property (p_tm)
        else $error("wrong transfer modifier");
    property p_exc_super;
        proc_state == 2'h1 |-> stack_super && (!bus_req || tm_out[2]);
    endproperty
    a_exc_super: assert property (p_exc_super)
        else $error("exception cycle not supervisor");
    property p_mode;
        super_mode == status_word[13] &&
            condition_flag_byte == status_word[7:0];
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode does not follow status word");
    property p_user_sw;
        instr_valid && instr_sw_write && !instr_privileged && !super_mode
            && proc_state == 2'h0
            |=> status_word[15:8] == $past(status_word[15:8]);
    endproperty
    a_user_sw: assert property (p_user_sw)
        else $error("user write reached upper status byte");
    property p_refuse;
        instr_valid && instr_privileged && proc_state == 2'h0
            |-> instr_refused == !super_mode;
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("privileged refusal wrong");
    property p_flush;
        instr_valid && (instr_sw_write || instr_rfe) && super_mode &&
            proc_state == 2'h0 |=> ##[0:1] pipe_flush;
    endproperty
    a_flush: assert property (p_flush)
        else $error("no pipeline flush");
    property p_entry;
        proc_state == 2'h0 && instr_valid && instr_trap && !stopped
            |=> sw_push && sw_push_data == $past(status_word);
    endproperty
    a_entry: assert property (p_entry)
        else $error("exception entry did not push status word");
    property p_stop_bus;
        bus_allowed == (bus_req && !stopped && !halted);
    endproperty
    a_stop_bus: assert property (p_stop_bus)
        else $error("bus allowed while stopped or halted");

    c_halt: cover property (halted);
    c_vector: cover property (vector_fetch);
    c_flush: cover property (pipe_flush);
    c_stop: cover property (stopped && bus_req);
endmodule : pspc_core_monitor

bind pspc_core pspc_core_monitor pspc_core_monitor_i (
    .clk_sys, .rst, .instr_valid, .instr_privileged, .instr_trap,
    .instr_sw_write, .instr_rfe, .bus_req, .bus_prog, .access_error,
    .address_error, .tm_out, .bus_allowed, .stack_super, .status_word,
    .condition_flag_byte, .super_mode, .proc_state, .stopped, .halted,
    .pipe_flush, .sw_push, .sw_push_data, .vector_fetch, .instr_refused
);
`default_nettype wire

// ===== verification/pspc_core_tb.sv
// Self-checking testbench for the state and privilege control block.
// Assumes the bound checker file is compiled alongside.
`timescale 1ns/1ns
`default_nettype none

module pspc_core_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic instr_valid, instr_privileged, instr_stop, instr_trap;
    logic trace_pending, instr_sw_write, instr_rfe, handler_first;
    logic wake_event, reg_acc_valid, gpr_we, bus_req, bus_prog;
    logic bus_done, access_error, address_error;
    logic [3:0] trap_num, gpr_waddr, gpr_raddr;
    logic [15:0] sw_wdata, rfe_sw, status_word, sw_push_data;
    logic [5:0] reg_acc_idx;
    logic [31:0] gpr_wdata, gpr_rdata;
    logic [2:0] tm_out;
    logic bus_allowed, stack_super, super_mode, stopped, halted;
    logic pipe_flush, sw_push, vector_fetch, instr_refused;
    logic reg_acc_refused;
    logic [7:0] condition_flag_byte, vector_num;
    logic [1:0] proc_state;
    int miscompares = 0;
    int cmp_count = 0;
    int cyc_count = 0;

    pspc_core pspc_core_i (
        .clk_sys, .rst, .instr_valid, .instr_privileged, .instr_stop,
        .instr_trap, .trap_num, .trace_pending, .instr_sw_write,
        .instr_rfe, .sw_wdata, .rfe_sw, .handler_first, .wake_event,
        .reg_acc_valid, .reg_acc_idx, .gpr_we, .gpr_waddr, .gpr_wdata,
        .gpr_raddr, .gpr_rdata, .bus_req, .bus_prog, .bus_done,
        .access_error, .address_error, .tm_out, .bus_allowed,
        .stack_super, .status_word, .condition_flag_byte, .super_mode,
        .proc_state, .stopped, .halted, .pipe_flush, .sw_push,
        .sw_push_data, .vector_fetch, .vector_num, .instr_refused,
        .reg_acc_refused
    );

    always #25 clk_sys = ~clk_sys;

    // Cuts a hung run short.
    always @(posedge clk_sys) begin
        cyc_count++;
        if (cyc_count == 5000) begin
            miscompares++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic step();
        @(posedge clk_sys);
        #5;
    endtask : step

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected %s exp %h got %h", name, exp, got);
            miscompares++;
        end
    endtask : chk

    task automatic idle();
        {instr_valid, instr_privileged, instr_stop, instr_trap} = '0;
        {instr_sw_write, instr_rfe, handler_first, wake_event} = '0;
        {trace_pending, reg_acc_valid, gpr_we, bus_req} = '0;
        {bus_prog, bus_done, access_error, address_error} = '0;
    endtask : idle

    task automatic do_reset();
        rst = 1'b1;
        repeat (10) step();
        rst = 1'b0;
        chk("status_word", 16'h2700, status_word);
        chk("proc_state", 0, proc_state);
    endtask : do_reset

    // Class bits: privileged, stop, trap, status write, return.
    task automatic issue(logic [4:0] cls, logic exp_ref);
        {instr_privileged, instr_stop, instr_trap} = cls[4:2];
        {instr_sw_write, instr_rfe} = cls[1:0];
        instr_valid = 1'b1;
        #1;
        chk("instr_refused", exp_ref, instr_refused);
        step();
        idle();
    endtask : issue

    task automatic chk_flush();
        logic f;
        f = pipe_flush;
        step();
        chk("pipe_flush", 1, f);
        chk("pipe_flush", 0, pipe_flush);
    endtask : chk_flush

    task automatic pulse_done();
        bus_done = 1'b1;
        step();
        bus_done = 1'b0;
        step();
    endtask : pulse_done

    // Walks one exception sequence from the cycle after entry.
    task automatic exc(logic [7:0] vec, logic [15:0] old);
        int i;
        chk("proc_state", 1, proc_state);
        chk("sw_push", 1, sw_push);
        chk("sw_push_data", old, sw_push_data);
        chk("super_mode", old[13], super_mode);
        bus_req = 1'b1;
        #1;
        chk("tm_out", pspc_pkg::TM_SUPER_DATA, tm_out);
        chk("stack_super", 1, stack_super);
        pulse_done();
        for (i = 0; i < 5 && vector_fetch !== 1'b1; i++) step();
        chk("vector_fetch", 1, vector_fetch);
        chk("vector_num", vec, vector_num);
        chk("super_mode", 1, super_mode);
        repeat (5) pulse_done();
        chk("proc_state", 1, proc_state);
        bus_req = 1'b0;
        handler_first = 1'b1;
        step();
        handler_first = 1'b0;
        chk("proc_state", 0, proc_state);
    endtask : exc

    task automatic t_regs(logic sup);
        logic [5:0] idx[5] = '{6'h05, 6'h11, 6'h12, 6'h18, 6'h1b};
        reg_acc_valid = 1'b1;
        foreach (idx[k]) begin
            reg_acc_idx = idx[k];
            #1;
            chk("reg_acc_refused", !sup &&
                idx[k] >= pspc_pkg::REG_IDX_FIRST_SUPER,
                reg_acc_refused);
        end
        reg_acc_valid = 1'b0;
        step();
        $display("test regs done");
    endtask : t_regs

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_modes();
        sw_wdata = 16'h0000;
        issue(5'h12, 1'b0);
        chk_flush();
        chk("super_mode", 0, super_mode);
        bus_req = 1'b1;
        bus_prog = 1'b1;
        #1;
        chk("tm_out", pspc_pkg::TM_USER_PROG, tm_out);
        bus_prog = 1'b0;
        #1;
        chk("tm_out", pspc_pkg::TM_USER_DATA, tm_out);
        step();
        idle();
        t_regs(1'b0);
        sw_wdata = 16'hff5a;
        issue(5'h02, 1'b0);
        chk("status_word", 16'h005a, status_word);
        $display("test modes done");
    endtask : t_modes

    task automatic t_exceptions();
        issue(5'h18, 1'b1);
        chk("stopped", 0, stopped);
        exc(pspc_pkg::VEC_PRIV_VIOLATION, 16'h005a);
        rfe_sw = 16'h0000;
        issue(5'h11, 1'b0);
        chk_flush();
        chk("super_mode", 0, super_mode);
        trap_num = 4'h7;
        issue(5'h04, 1'b0);
        exc(pspc_pkg::VEC_TRAP_BASE + 8'h07, 16'h0000);
        trace_pending = 1'b1;
        step();
        trace_pending = 1'b0;
        exc(pspc_pkg::VEC_TRACE, 16'h2000);
        t_regs(1'b1);
        $display("test exceptions done");
    endtask : t_exceptions

    task automatic t_stop_gpr();
        issue(5'h18, 1'b0);
        bus_req = 1'b1;
        #1;
        chk("stopped", 1, stopped);
        chk("bus_allowed", 0, bus_allowed);
        wake_event = 1'b1;
        step();
        wake_event = 1'b0;
        chk("bus_allowed", 1, bus_allowed);
        {gpr_we, gpr_waddr, gpr_wdata} = {1'b1, 4'hf, 32'hdeadbeef};
        step();
        {gpr_waddr, gpr_wdata} = {4'h0, 32'h12345678};
        step();
        gpr_we = 1'b0;
        gpr_raddr = 4'hf;
        step();
        chk("gpr_rdata", 32'hdeadbeef, gpr_rdata);
        gpr_raddr = 4'h0;
        step();
        chk("gpr_rdata", 32'h12345678, gpr_rdata);
        idle();
        $display("test stop and registers done");
    endtask : t_stop_gpr

    task automatic t_halt();
        for (int k = 0; k < 2; k++) begin
            issue(5'h04, 1'b0);
            {access_error, address_error} = (k == 0) ? 2'b10 : 2'b01;
            step();
            {access_error, address_error} = 2'b00;
            chk("halted", 1, halted);
            issue(5'h04, 1'b0);
            handler_first = 1'b1;
            wake_event = 1'b1;
            bus_req = 1'b1;
            step();
            chk("halted", 1, halted);
            chk("bus_allowed", 0, bus_allowed);
            idle();
            do_reset();
        end
        $display("test halt done");
    endtask : t_halt

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    initial begin
        idle();
        {trap_num, gpr_waddr, gpr_raddr, reg_acc_idx} = '0;
        {sw_wdata, rfe_sw, gpr_wdata} = '0;
        #5;
        do_reset();
        t_modes();
        t_exceptions();
        t_stop_gpr();
        t_halt();
        results();
    end
endmodule : pspc_core_tb
`default_nettype wire
